// >>> shared/pcfg_pkg.sv
// constants for the port 0 / port 1 pin configuration block
package pcfg_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PORT0_MODE_HIGH = 8'he0;
	localparam logic [7:0] IDX_PORT0_MODE_LOW = 8'he1;
	localparam logic [7:0] IDX_PORT0_PULLUP_ENABLE = 8'he2;
	localparam logic [7:0] IDX_PORT1_MODE_HIGH = 8'he4;
	localparam logic [7:0] IDX_PORT1_MODE_LOW = 8'he5;
	localparam logic [7:0] IDX_PORT1_PENDING_FLAGS = 8'hf7;
	localparam logic [7:0] IDX_PORT1_IRQ_MASK = 8'hf8;
	localparam logic [7:0] IDX_PORT0_DATA = 8'hd0;
	localparam logic [7:0] IDX_PORT1_DATA = 8'hd1;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_MSB = 9;

	// reset value of every register
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	// port 0 mode codes
	localparam logic [1:0] P0_INPUT = 2'h0;
	localparam logic [1:0] P0_OPEN_DRAIN = 2'h1;
	localparam logic [1:0] P0_ALT = 2'h2;
	localparam logic [1:0] P0_PUSH_PULL = 2'h3;

	// port 1 mode codes
	localparam logic [1:0] P1_FALL_PULLUP = 2'h0;
	localparam logic [1:0] P1_RISE = 2'h1;
	localparam logic [1:0] P1_BOTH = 2'h2;
	localparam logic [1:0] P1_PUSH_PULL = 2'h3;

	// port 0 pin positions of timer functions
	localparam int unsigned PIN_TIMER2_OUT = 7;
	localparam int unsigned PIN_TIMER2_CLK = 6;
	localparam int unsigned PIN_TIMER1_OUT = 5;
	localparam int unsigned PIN_TIMER1_CLK = 4;
	localparam int unsigned PIN_TIMER0_OUT = 3;
	localparam int unsigned PIN_TIMER0_CAP = 2;
	localparam int unsigned PIN_TIMER0_CLK = 1;
	// pins on which code 10 selects a timer output
	localparam logic [7:0] P0_ALT_PINS = 8'ha8;

	localparam int unsigned PORT_PINS = 8;
	localparam int unsigned SYNC_STAGES = 2;

	// bus answer sequencer
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} pcfg_bus_state_type;
endpackage : pcfg_pkg

// >>> shared/pcfg_edge_if.sv
// per-pin link between the top and an edge detector
`timescale 1ns/1ps
interface pcfg_edge_if;
	logic [1:0] mode;
	logic level;
	logic edge_event;
	modport detector (input mode, input level, output edge_event);
	modport owner (output mode, output level, input edge_event);
endinterface : pcfg_edge_if

// >>> verilog/pcfg_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pcfg_sync #(
	parameter int unsigned WIDTH = 16
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} pcfg_sync_state_type;

	pcfg_sync_state_type state;
	pcfg_sync_state_type next_state;

	if (WIDTH < 1) begin : g_bad_width
		$error("pcfg_sync: WIDTH must be at least 1");
	end

	// first stage feeds only the second
	always_comb begin
		next_state.stage1 = async_i;
		next_state.stage2 = state.stage1;
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= '0;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	assign sync_o = state.stage2;
endmodule : pcfg_sync

// >>> verilog/pcfg_edge_detect.sv
// edge detector for one port 1 pin
`timescale 1ns/1ps
module pcfg_edge_detect (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	pcfg_edge_if.detector pin
);
	// edges after reset until the synchroniser and prev hold real pin levels
	localparam logic [1:0] SETTLE_DONE = 2'(pcfg_pkg::SYNC_STAGES + 1);

	typedef struct packed {
		logic prev;
		logic [1:0] settle;
	} pcfg_edge_state_type;

	pcfg_edge_state_type state;
	pcfg_edge_state_type next_state;
	logic rise;
	logic fall;
	logic primed;

	if (pcfg_pkg::SYNC_STAGES + 1 > 3) begin : g_bad_settle
		$error("pcfg_edge_detect: settle counter too narrow for SYNC_STAGES");
	end

	// no false edge while reset zeros drain out of the synchroniser
	assign primed = (state.settle == SETTLE_DONE);

	// compare with previous sample
	always_comb begin
		next_state.prev = pin.level;
		next_state.settle = primed ? state.settle : state.settle + 2'h1;
		rise = primed && pin.level && !state.prev;
		fall = primed && !pin.level && state.prev;
	end

	// select edge by mode; output mode detects nothing
	always_comb begin
		case (pin.mode)
			pcfg_pkg::P1_FALL_PULLUP: pin.edge_event = ce_i && fall;
			pcfg_pkg::P1_RISE: pin.edge_event = ce_i && rise;
			pcfg_pkg::P1_BOTH: pin.edge_event = ce_i && (rise || fall);
			pcfg_pkg::P1_PUSH_PULL: pin.edge_event = 1'b0;
			default: pin.edge_event = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= '0;
		end else if (ce_i) begin
			state <= next_state;
		end
	end
endmodule : pcfg_edge_detect

// >>> verilog/pcfg_port01.sv
// port 0 / port 1 pin configuration, pending flags and register slave
`timescale 1ns/1ps
module pcfg_port01 #(
	parameter int unsigned ADDR_W = 10
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// port 0 pins
	input wire logic [7:0] port0_pin_i,
	output logic [7:0] port0_pin_o,
	output logic [7:0] port0_pin_oe_o,
	output logic [7:0] port0_pullup_o,
	// port 1 pins
	input wire logic [7:0] port1_pin_i,
	output logic [7:0] port1_pin_o,
	output logic [7:0] port1_pin_oe_o,
	output logic [7:0] port1_pullup_o,
	// timer connections
	input wire logic timer2_output_i,
	input wire logic timer1_output_i,
	input wire logic timer0_output_i,
	input wire logic timer0_pwm_output_i,
	input wire logic timer0_pwm_select_i,
	output logic timer2_ext_clock_o,
	output logic timer1_ext_clock_o,
	output logic timer0_capture_input_o,
	output logic timer0_ext_clock_o,
	// interrupt side
	output logic [7:0] ext_irq_line_o,
	output logic irq_o
);
	typedef struct packed {
		pcfg_pkg::pcfg_bus_state_type bus;
		logic [31:0] readdata;
		logic [7:0] port0_mode_high;
		logic [7:0] port0_mode_low;
		logic [7:0] port0_pullup_enable;
		logic [7:0] port1_mode_high;
		logic [7:0] port1_mode_low;
		logic [7:0] port1_pending_flags;
		logic [7:0] port1_irq_mask;
		logic [7:0] port0_data;
		logic [7:0] port1_data;
	} pcfg_top_state_type;

	pcfg_top_state_type state;
	pcfg_top_state_type next_state;

	logic [15:0] pins_sync;
	logic [7:0] port0_level;
	logic [7:0] port1_level;
	logic [15:0] port0_modes;
	logic [15:0] port1_modes;
	logic [7:0] edge_events;
	logic [7:0] index;
	logic aligned;
	logic request;
	logic write_lane;
	logic [7:0] wbyte;
	logic [7:0] read_byte;
	logic [7:0] pending_clear;
	logic [7:0] alt_value;
	logic timer0_drive;

	if (ADDR_W < pcfg_pkg::IDX_MSB + 1) begin : g_bad_addr
		$error("pcfg_port01: ADDR_W too small for the register map");
	end

	// pin inputs cross into the clock domain
	pcfg_sync #(
		.WIDTH(16)
	) u_sync (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.async_i({port1_pin_i, port0_pin_i}),
		.sync_o(pins_sync)
	);

	assign port0_level = pins_sync[7:0];
	assign port1_level = pins_sync[15:8];
	// pin n mode sits at bits 2n+1:2n, high register holds pins 7..4
	assign port0_modes = {state.port0_mode_high, state.port0_mode_low};
	assign port1_modes = {state.port1_mode_high, state.port1_mode_low};

	// one edge detector per port 1 pin
	pcfg_edge_if edge_link[pcfg_pkg::PORT_PINS] ();
	for (genvar g = 0; g < pcfg_pkg::PORT_PINS; g++) begin : g_edge
		assign edge_link[g].mode = port1_modes[2*g+1:2*g];
		assign edge_link[g].level = port1_level[g];
		assign edge_events[g] = edge_link[g].edge_event;
		pcfg_edge_detect u_edge (
			.clock_i(clock_i),
			.arst_n_i(arst_n_i),
			.ce_i(ce_i),
			.pin(edge_link[g])
		);
	end

	// bus decode
	assign index = avs_address_i[pcfg_pkg::IDX_MSB:pcfg_pkg::IDX_LSB];
	assign aligned = (avs_address_i[1:0] == 2'h0);
	assign request = avs_read_i || avs_write_i;
	assign write_lane = avs_write_i && avs_byteenable_i[0] && aligned;
	assign wbyte = avs_writedata_i[7:0];

	// read multiplexer, data registers show pin levels
	always_comb begin
		read_byte = 8'h00;
		if (aligned) begin
			case (index)
				pcfg_pkg::IDX_PORT0_MODE_HIGH: read_byte = state.port0_mode_high;
				pcfg_pkg::IDX_PORT0_MODE_LOW: read_byte = state.port0_mode_low;
				pcfg_pkg::IDX_PORT0_PULLUP_ENABLE: read_byte = state.port0_pullup_enable;
				pcfg_pkg::IDX_PORT1_MODE_HIGH: read_byte = state.port1_mode_high;
				pcfg_pkg::IDX_PORT1_MODE_LOW: read_byte = state.port1_mode_low;
				pcfg_pkg::IDX_PORT1_PENDING_FLAGS: read_byte = state.port1_pending_flags;
				pcfg_pkg::IDX_PORT1_IRQ_MASK: read_byte = state.port1_irq_mask;
				pcfg_pkg::IDX_PORT0_DATA: read_byte = port0_level;
				pcfg_pkg::IDX_PORT1_DATA: read_byte = port1_level;
				default: read_byte = 8'h00;
			endcase
		end
	end

	// writing zero to a pending bit clears it
	always_comb begin
		pending_clear = 8'h00;
		if (state.bus == pcfg_pkg::BUS_ACK && write_lane &&
			index == pcfg_pkg::IDX_PORT1_PENDING_FLAGS) begin
			pending_clear = ~wbyte;
		end
	end

	// register file and bus sequencer
	always_comb begin
		next_state = state;
		// a new edge wins over a clear in the same cycle
		next_state.port1_pending_flags =
			(state.port1_pending_flags & ~pending_clear) | edge_events;
		case (state.bus)
			pcfg_pkg::BUS_IDLE: begin
				if (request) begin
					next_state.bus = pcfg_pkg::BUS_ACK;
					next_state.readdata = avs_read_i ? {24'h000000, read_byte} :
						pcfg_pkg::READ_UNMAPPED;
				end
			end
			pcfg_pkg::BUS_ACK: begin
				next_state.bus = pcfg_pkg::BUS_IDLE;
				if (write_lane) begin
					case (index)
						pcfg_pkg::IDX_PORT0_MODE_HIGH: next_state.port0_mode_high = wbyte;
						pcfg_pkg::IDX_PORT0_MODE_LOW: next_state.port0_mode_low = wbyte;
						pcfg_pkg::IDX_PORT0_PULLUP_ENABLE: begin
							next_state.port0_pullup_enable = wbyte;
						end
						pcfg_pkg::IDX_PORT1_MODE_HIGH: next_state.port1_mode_high = wbyte;
						pcfg_pkg::IDX_PORT1_MODE_LOW: next_state.port1_mode_low = wbyte;
						pcfg_pkg::IDX_PORT1_IRQ_MASK: next_state.port1_irq_mask = wbyte;
						pcfg_pkg::IDX_PORT0_DATA: next_state.port0_data = wbyte;
						pcfg_pkg::IDX_PORT1_DATA: next_state.port1_data = wbyte;
						default: next_state.port0_data = state.port0_data;
					endcase
				end
			end
			default: next_state.bus = pcfg_pkg::BUS_IDLE;
		endcase
	end

	// all registers clear on reset
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state.bus <= pcfg_pkg::BUS_IDLE;
			state.readdata <= pcfg_pkg::READ_UNMAPPED;
			state.port0_mode_high <= pcfg_pkg::REG_RESET;
			state.port0_mode_low <= pcfg_pkg::REG_RESET;
			state.port0_pullup_enable <= pcfg_pkg::REG_RESET;
			state.port1_mode_high <= pcfg_pkg::REG_RESET;
			state.port1_mode_low <= pcfg_pkg::REG_RESET;
			state.port1_pending_flags <= pcfg_pkg::REG_RESET;
			state.port1_irq_mask <= pcfg_pkg::REG_RESET;
			state.port0_data <= pcfg_pkg::REG_RESET;
			state.port1_data <= pcfg_pkg::REG_RESET;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	// one wait state; no answer while the clock enable freezes the registers
	assign avs_waitrequest_o = !(ce_i && request && state.bus == pcfg_pkg::BUS_ACK);
	assign avs_readdata_o = state.readdata;

	// timer outputs routed to port 0 alternate pins
	assign timer0_drive = timer0_pwm_select_i ? timer0_pwm_output_i : timer0_output_i;
	always_comb begin
		alt_value = 8'h00;
		alt_value[pcfg_pkg::PIN_TIMER2_OUT] = timer2_output_i;
		alt_value[pcfg_pkg::PIN_TIMER1_OUT] = timer1_output_i;
		alt_value[pcfg_pkg::PIN_TIMER0_OUT] = timer0_drive;
	end

	// port 0 drivers per mode
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			case (port0_modes[2*i +: 2])
				pcfg_pkg::P0_OPEN_DRAIN: begin
					port0_pin_o[i] = 1'b0;
					port0_pin_oe_o[i] = !state.port0_data[i];
				end
				pcfg_pkg::P0_PUSH_PULL: begin
					port0_pin_o[i] = state.port0_data[i];
					port0_pin_oe_o[i] = 1'b1;
				end
				pcfg_pkg::P0_ALT: begin
					// code 10 on a pin with no timer output leaves it an input
					port0_pin_o[i] = alt_value[i] && pcfg_pkg::P0_ALT_PINS[i];
					port0_pin_oe_o[i] = pcfg_pkg::P0_ALT_PINS[i];
				end
				default: begin
					port0_pin_o[i] = 1'b0;
					port0_pin_oe_o[i] = 1'b0;
				end
			endcase
		end
	end

	// timer inputs pass only in input mode
	always_comb begin
		timer2_ext_clock_o = (port0_modes[2*pcfg_pkg::PIN_TIMER2_CLK +: 2] == pcfg_pkg::P0_INPUT) &&
			port0_level[pcfg_pkg::PIN_TIMER2_CLK];
		timer1_ext_clock_o = (port0_modes[2*pcfg_pkg::PIN_TIMER1_CLK +: 2] == pcfg_pkg::P0_INPUT) &&
			port0_level[pcfg_pkg::PIN_TIMER1_CLK];
		timer0_capture_input_o =
			(port0_modes[2*pcfg_pkg::PIN_TIMER0_CAP +: 2] == pcfg_pkg::P0_INPUT) &&
			port0_level[pcfg_pkg::PIN_TIMER0_CAP];
		timer0_ext_clock_o = (port0_modes[2*pcfg_pkg::PIN_TIMER0_CLK +: 2] == pcfg_pkg::P0_INPUT) &&
			port0_level[pcfg_pkg::PIN_TIMER0_CLK];
	end

	// pull-up bit n to pin n
	assign port0_pullup_o = state.port0_pullup_enable;

	// port 1 drivers and pull-ups
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			port1_pin_oe_o[i] = (port1_modes[2*i +: 2] == pcfg_pkg::P1_PUSH_PULL);
			port1_pin_o[i] = port1_pin_oe_o[i] && state.port1_data[i];
			port1_pullup_o[i] = (port1_modes[2*i +: 2] == pcfg_pkg::P1_FALL_PULLUP);
		end
	end

	// each pending flag is its own irq line; mask gates the summary
	assign ext_irq_line_o = state.port1_pending_flags;
	assign irq_o = |(state.port1_pending_flags & state.port1_irq_mask);
endmodule : pcfg_port01

// >>> sim/pcfg_pin_model.sv
// far side of the block: pin drivers, pull-ups and timer signal sources
`timescale 1ns/1ps
module pcfg_pin_model (
	input wire logic clock_i,
	input wire logic [7:0] port0_drive_i,
	input wire logic [7:0] port0_oe_i,
	input wire logic [7:0] port0_pullup_i,
	input wire logic [7:0] port0_ext_i,
	input wire logic [7:0] port0_ext_en_i,
	input wire logic [7:0] port1_drive_i,
	input wire logic [7:0] port1_oe_i,
	input wire logic [7:0] port1_pullup_i,
	input wire logic [7:0] port1_ext_i,
	input wire logic [7:0] port1_ext_en_i,
	output logic [7:0] port0_level_o,
	output logic [7:0] port1_level_o,
	output logic [3:0] timer_o
);
	logic [7:0] float0 = 8'h00;
	logic [7:0] float1 = 8'h00;
	logic [3:0] tick = 4'h0;
	// wire level: device drive first, then outside driver, then pull-up, else wandering
	assign port0_level_o = (port0_oe_i & port0_drive_i) | (~port0_oe_i & port0_ext_en_i & port0_ext_i)
		| (~port0_oe_i & ~port0_ext_en_i & (port0_pullup_i | float0));
	assign port1_level_o = (port1_oe_i & port1_drive_i) | (~port1_oe_i & port1_ext_en_i & port1_ext_i)
		| (~port1_oe_i & ~port1_ext_en_i & (port1_pullup_i | float1));
	assign timer_o = tick;
	// released lines flip each cycle; timers run free
	always @(posedge clock_i) begin
		float0 <= ~port0_level_o;
		float1 <= ~port1_level_o;
		tick <= tick + 4'h1;
	end
endmodule : pcfg_pin_model

// >>> sim/pcfg_port01_props.sv
// assertions on the pin configuration block ports
`timescale 1ns/1ps
module pcfg_port01_props #(
	parameter int unsigned ADDR_W = 10
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [7:0] port0_pin_oe_o,
	input wire logic [7:0] port0_pullup_o,
	input wire logic [7:0] port1_pin_i,
	input wire logic [7:0] port1_pin_oe_o,
	input wire logic [7:0] port1_pullup_o,
	input wire logic timer2_ext_clock_o,
	input wire logic [7:0] ext_irq_line_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	// write answered this cycle, byte lane 0 enabled
	sequence s_answer;
		ce_i && avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	endsequence
	sequence s_pins_quiet;
		$stable(port1_pin_i)[*6];
	endsequence
	property p_pullup_wr;
		s_answer ##0 avs_address_i == {pcfg_pkg::IDX_PORT0_PULLUP_ENABLE, 2'b00}
		|=> port0_pullup_o == $past(avs_writedata_i[7:0]);
	endproperty
	a_pullup_wr: assert property (p_pullup_wr)
		else $error("pull-up output differs from written byte");
	property p_one_wait;
		ce_i && $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("bus answer not after exactly one wait");
	property p_idle_wait;
		!(avs_read_i || avs_write_i) |-> avs_waitrequest_o;
	endproperty
	a_idle_wait: assert property (p_idle_wait)
		else $error("waitrequest low without a request");
	property p_read_upper;
		!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000;
	endproperty
	a_read_upper: assert property (p_read_upper)
		else $error("upper read data bits not zero");
	property p_irq_cause;
		irq_o |-> ext_irq_line_o != 8'h00;
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without a pending flag");
	property p_pp_no_pullup;
		(port1_pin_oe_o & port1_pullup_o) == 8'h00;
	endproperty
	a_pp_no_pullup: assert property (p_pp_no_pullup)
		else $error("driven port 1 pin has pull-up on");
	property p_tclk_quiet;
		port0_pin_oe_o[6] |-> !timer2_ext_clock_o;
	endproperty
	a_tclk_quiet: assert property (p_tclk_quiet)
		else $error("timer clock fed from a driven pin");
	property p_no_spurious;
		s_pins_quiet |-> (ext_irq_line_o & ~$past(ext_irq_line_o)) == 8'h00;
	endproperty
	a_no_spurious: assert property (p_no_spurious)
		else $error("pending flag set with quiet pins");
	property p_clear;
		s_pins_quiet ##0 s_answer ##0 avs_writedata_i[7:0] == 8'h00
		##0 avs_address_i == {pcfg_pkg::IDX_PORT1_PENDING_FLAGS, 2'b00} |=> ext_irq_line_o == 8'h00;
	endproperty
	a_clear: assert property (p_clear)
		else $error("pending flags not cleared by zero write");
endmodule : pcfg_port01_props
bind pcfg_port01 pcfg_port01_props #(.ADDR_W(ADDR_W)) props_u (.clock_i, .arst_n_i, .ce_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
	.avs_waitrequest_o, .port0_pin_oe_o, .port0_pullup_o, .port1_pin_i, .port1_pin_oe_o,
	.port1_pullup_o, .timer2_ext_clock_o, .ext_irq_line_o, .irq_o);

// >>> sim/pcfg_port01_tb_top.sv
// self-checking bench for the pin configuration block
`timescale 1ns/1ps
module pcfg_port01_tb_top;
	logic clock_i, arst_n_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
	logic [9:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic [3:0] avs_byteenable_i, tmr;
	logic [7:0] port0_pin_i, port0_pin_o, port0_pin_oe_o, port0_pullup_o, ext_irq_line_o;
	logic [7:0] port1_pin_i, port1_pin_o, port1_pin_oe_o, port1_pullup_o, p0_ext, p0_ext_en, p1_ext;
	logic timer0_pwm_select_i, timer2_ext_clock_o, timer1_ext_clock_o;
	logic timer0_capture_input_o, timer0_ext_clock_o;
	int n_mismatch = 0;
	int check_count = 0;
	int cycle_count = 0;
	pcfg_port01 dut_u (.clock_i, .arst_n_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .port0_pin_i,
		.port0_pin_o, .port0_pin_oe_o, .port0_pullup_o, .port1_pin_i, .port1_pin_o, .port1_pin_oe_o,
		.port1_pullup_o, .timer2_output_i(tmr[1]), .timer1_output_i(tmr[2]),
		.timer0_output_i(tmr[3]), .timer0_pwm_output_i(tmr[0]), .timer0_pwm_select_i,
		.timer2_ext_clock_o, .timer1_ext_clock_o, .timer0_capture_input_o, .timer0_ext_clock_o,
		.ext_irq_line_o, .irq_o);
	pcfg_pin_model model_u (.clock_i, .port0_drive_i(port0_pin_o), .port0_oe_i(port0_pin_oe_o),
		.port0_pullup_i(port0_pullup_o), .port0_ext_i(p0_ext), .port0_ext_en_i(p0_ext_en),
		.port1_drive_i(port1_pin_o), .port1_oe_i(port1_pin_oe_o), .port1_pullup_i(port1_pullup_o),
		.port1_ext_i(p1_ext), .port1_ext_en_i(8'hff), .port0_level_o(port0_pin_i),
		.port1_level_o(port1_pin_i), .timer_o(tmr));
	// clock and hang guard
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask : cyc
	// one bus transfer held until waitrequest is sampled low at a rising edge
	task bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clock_i);
		avs_address_i <= {idx, 2'b00};
		avs_read_i <= !wr;
		avs_write_i <= wr;
		avs_writedata_i <= {24'h000000, wd};
		do begin
			@(posedge clock_i);
		end while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o[7:0];
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		// one more edge so the written register shows on the outputs
		@(posedge clock_i);
	endtask : bus
	task wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [7:0] d;
		bus(idx, 1'b1, wd, d);
	endtask : wr
	task rdchk(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		bus(idx, 1'b0, 8'h00, d);
		chk(d, exp);
	endtask : rdchk
	task t_regs;
		logic [7:0] r [5];
		r = '{pcfg_pkg::IDX_PORT0_MODE_HIGH, pcfg_pkg::IDX_PORT0_MODE_LOW,
			pcfg_pkg::IDX_PORT0_PULLUP_ENABLE, pcfg_pkg::IDX_PORT1_MODE_HIGH, pcfg_pkg::IDX_PORT1_MODE_LOW};
		chk(port1_pullup_o, 8'hff);
		for (int i = 0; i < 5; i++) begin
			rdchk(r[i], 8'h00);
			wr(r[i], 8'h5a ^ 8'(i));
			rdchk(r[i], 8'h5a ^ 8'(i));
			wr(r[i], 8'h00);
		end
		rdchk(8'h10, 8'h00);
		avs_byteenable_i <= 4'he;
		wr(pcfg_pkg::IDX_PORT0_PULLUP_ENABLE, 8'hff);
		avs_byteenable_i <= 4'hf;
		rdchk(pcfg_pkg::IDX_PORT0_PULLUP_ENABLE, 8'h00);
		$display("test registers done");
	endtask : t_regs
	task t_port0;
		wr(pcfg_pkg::IDX_PORT0_PULLUP_ENABLE, 8'ha5);
		chk(port0_pullup_o, 8'ha5);
		wr(pcfg_pkg::IDX_PORT0_DATA, 8'h40);
		wr(pcfg_pkg::IDX_PORT0_MODE_HIGH, 8'hb9);
		wr(pcfg_pkg::IDX_PORT0_MODE_LOW, 8'h82);
		chk(port0_pin_oe_o, 8'hf8);
		for (int i = 0; i < 4; i++) begin
			cyc(1);
			chk({3'h0, port0_pin_o[7:3]}, {3'h0, tmr[1], 1'b1, tmr[2], 1'b0, tmr[3]});
		end
		timer0_pwm_select_i <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			cyc(1);
			chk({7'h0, port0_pin_o[3]}, {7'h0, tmr[0]});
		end
		p0_ext_en <= 8'h56;
		p0_ext <= 8'h04;
		cyc(4);
		chk({6'h0, timer0_capture_input_o, timer0_ext_clock_o}, 8'h02);
		wr(pcfg_pkg::IDX_PORT0_MODE_HIGH, 8'h00);
		p0_ext <= 8'h52;
		cyc(4);
		chk({4'h0, timer2_ext_clock_o, timer1_ext_clock_o, timer0_capture_input_o,
			timer0_ext_clock_o}, 8'h0d);
		$display("test port 0 done");
	endtask : t_port0
	task t_port1;
		logic [7:0] e;
		wr(pcfg_pkg::IDX_PORT1_IRQ_MASK, 8'hff);
		for (int k = 0; k < 3; k++) begin
			wr(pcfg_pkg::IDX_PORT1_MODE_HIGH, {4{2'(k)}});
			wr(pcfg_pkg::IDX_PORT1_MODE_LOW, {4{2'(k)}});
			chk(port1_pullup_o, (k == 0) ? 8'hff : 8'h00);
			cyc(6);
			wr(pcfg_pkg::IDX_PORT1_PENDING_FLAGS, 8'h00);
			for (int f = 0; f < 2; f++) begin
				p1_ext <= ~p1_ext;
				e = ((f == 0 && k != 1) || (f == 1 && k != 0)) ? 8'hff : 8'h00;
				cyc(6);
				rdchk(pcfg_pkg::IDX_PORT1_PENDING_FLAGS, e);
				chk(ext_irq_line_o, e);
				chk({7'h0, irq_o}, {7'h0, e[0]});
				if (f == 0) wr(pcfg_pkg::IDX_PORT1_PENDING_FLAGS, 8'h00);
			end
		end
		wr(pcfg_pkg::IDX_PORT1_IRQ_MASK, 8'h00);
		chk({7'h0, irq_o}, 8'h00);
		wr(pcfg_pkg::IDX_PORT1_IRQ_MASK, 8'h01);
		wr(pcfg_pkg::IDX_PORT1_PENDING_FLAGS, 8'hf0);
		rdchk(pcfg_pkg::IDX_PORT1_PENDING_FLAGS, 8'hf0);
		chk({7'h0, irq_o}, 8'h00);
		wr(pcfg_pkg::IDX_PORT1_MODE_HIGH, 8'hff);
		wr(pcfg_pkg::IDX_PORT1_MODE_LOW, 8'hff);
		wr(pcfg_pkg::IDX_PORT1_DATA, 8'h3c);
		chk(port1_pin_oe_o, 8'hff);
		chk(port1_pin_o, 8'h3c);
		cyc(6);
		wr(pcfg_pkg::IDX_PORT1_PENDING_FLAGS, 8'h00);
		wr(pcfg_pkg::IDX_PORT1_DATA, 8'hc3);
		chk(port1_pin_o, 8'hc3);
		cyc(6);
		rdchk(pcfg_pkg::IDX_PORT1_PENDING_FLAGS, 8'h00);
		$display("test port 1 done");
	endtask : t_port1
	// reset, then the scenarios in turn
	initial begin
		arst_n_i = 1'b0;
		ce_i = 1'b1;
		avs_address_i = 10'h000;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h00000000;
		avs_byteenable_i = 4'hf;
		timer0_pwm_select_i = 1'b0;
		p0_ext = 8'h00;
		p0_ext_en = 8'h00;
		p1_ext = 8'hff;
		repeat (12) @(posedge clock_i);
		arst_n_i <= 1'b1;
		t_regs();
		t_port0();
		t_port1();
		end_of_test();
	end
endmodule : pcfg_port01_tb_top
